// ===== verilog/ewo_enveloped_write_ordering.sv
// Purpose: orders the data tenures of pipelined bus transactions
// Assumes: arbiter pins are synchronous to clock; no address retry here
// Notes: single-beat tenures; busy held one clock per write tenure

`timescale 1ns/1ns

module ewo_enveloped_write_ordering (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic addr_req_valid,
  input wire logic addr_req_write,
  input wire logic [ewo_pkg::EWO_DATA_W-1:0] addr_req_data,
  output logic addr_req_ready,
  input wire logic address_tenure_grant_n,
  input wire logic data_tenure_grant_n,
  input wire logic write_first_modifier_n,
  input wire logic data_tenure_busy_n_in,
  output logic data_tenure_busy_n_out,
  output logic data_tenure_busy_oe,
  input wire logic [ewo_pkg::EWO_DATA_W-1:0] data_bus_in,
  output logic [ewo_pkg::EWO_DATA_W-1:0] data_bus_out,
  output logic data_bus_oe,
  output logic [ewo_pkg::EWO_DATA_W-1:0] read_data,
  output logic read_valid,
  output logic write_done
);

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [ewo_pkg::EWO_IDX_W:0] ewo_first_write(
    input logic [ewo_pkg::EWO_DEPTH-1:0] wr,
    input logic [ewo_pkg::EWO_CNT_W-1:0] cnt
  );
    logic [ewo_pkg::EWO_IDX_W:0] r;
    r = '0;
    for (int i = ewo_pkg::EWO_DEPTH - 1; i >= 0; i--) begin
      if (wr[i] && (i < cnt)) begin
        r = {1'h1, i[ewo_pkg::EWO_IDX_W-1:0]};
      end
    end
    return r;
  endfunction

  function automatic logic ewo_any_read(
    input logic [ewo_pkg::EWO_DEPTH-1:0] wr,
    input logic [ewo_pkg::EWO_CNT_W-1:0] cnt
  );
    logic r;
    r = 1'h0;
    for (int i = 0; i < ewo_pkg::EWO_DEPTH; i++) begin
      if (!wr[i] && (i < cnt)) begin
        r = 1'h1;
      end
    end
    return r;
  endfunction

  // --------------------------------------------------------------------
  // pending data tenure queue, oldest address tenure at index zero
  // --------------------------------------------------------------------
  logic [ewo_pkg::EWO_DEPTH-1:0] is_wr_ff;
  logic [ewo_pkg::EWO_DEPTH-1:0] nxt_is_wr;
  logic [ewo_pkg::EWO_DATA_W-1:0] data_ff [ewo_pkg::EWO_DEPTH];
  logic [ewo_pkg::EWO_DATA_W-1:0] nxt_data [ewo_pkg::EWO_DEPTH];
  logic [ewo_pkg::EWO_TAG_W-1:0] tag_ff [ewo_pkg::EWO_DEPTH];
  logic [ewo_pkg::EWO_TAG_W-1:0] nxt_tag [ewo_pkg::EWO_DEPTH];
  logic [ewo_pkg::EWO_CNT_W-1:0] count_ff;
  logic [ewo_pkg::EWO_CNT_W-1:0] nxt_count;
  logic [ewo_pkg::EWO_TAG_W-1:0] wr_push_tag_ff;
  logic [ewo_pkg::EWO_TAG_W-1:0] wr_next_tag_ff;
  ewo_pkg::ewo_tenure_e tenure_st_ff;
  ewo_pkg::ewo_tenure_e nxt_tenure_st;
  logic [ewo_pkg::EWO_DATA_W-1:0] data_out_ff;
  logic [ewo_pkg::EWO_DATA_W-1:0] read_data_ff;
  logic read_valid_ff;
  logic write_done_ff;

  logic addr_taken;
  logic qual_grant;
  logic wfm;
  logic [ewo_pkg::EWO_IDX_W:0] first_wr;
  logic any_read;
  logic use_wf;
  logic [ewo_pkg::EWO_IDX_W-1:0] sel_idx;
  logic [ewo_pkg::EWO_IDX_W-1:0] tail_idx;
  logic [ewo_pkg::EWO_DATA_W-1:0] sel_data;
  logic [ewo_pkg::EWO_TAG_W-1:0] sel_tag;
  logic start_wr;
  logic start_rd;

  // --------------------------------------------------------------------
  // grant decode and tenure selection
  // --------------------------------------------------------------------
  assign addr_req_ready = (count_ff != ewo_pkg::EWO_CNT_FULL);
  // write contents captured here, not at data grant
  assign addr_taken = !address_tenure_grant_n && addr_req_valid &&
                      addr_req_ready;
  // bus idle, own tenure done and something pending
  assign qual_grant = !data_tenure_grant_n && data_tenure_busy_n_in &&
                      (tenure_st_ff == ewo_pkg::EWO_IDLE) &&
                      (count_ff != ewo_pkg::EWO_CNT_ZERO);
  assign wfm = !write_first_modifier_n;
  assign first_wr = ewo_first_write(is_wr_ff, count_ff);
  assign any_read = ewo_any_read(is_wr_ff, count_ff);
  // modifier counts only with a qualified grant
  // oldest write only, so writes keep their order
  assign use_wf = qual_grant && wfm && first_wr[ewo_pkg::EWO_IDX_W];
  // head of queue otherwise
  assign sel_idx = use_wf ? first_wr[ewo_pkg::EWO_IDX_W-1:0] :
                   ewo_pkg::EWO_IDX_ZERO;
  assign tail_idx = count_ff[ewo_pkg::EWO_IDX_W-1:0];
  assign sel_data = data_ff[sel_idx];
  assign sel_tag = tag_ff[sel_idx];
  assign start_wr = qual_grant && is_wr_ff[sel_idx];
  // a grant without modifier completes the enveloping read
  assign start_rd = qual_grant && !is_wr_ff[sel_idx];

  // --------------------------------------------------------------------
  // queue update: remove selected entry, append new address tenure
  // --------------------------------------------------------------------
  always_comb begin
    nxt_is_wr = is_wr_ff;
    nxt_data = data_ff;
    nxt_tag = tag_ff;
    nxt_count = count_ff;
    if (qual_grant) begin
      // entries behind the removed one close up
      for (int i = 0; i < ewo_pkg::EWO_DEPTH - 1; i++) begin
        if (i >= sel_idx) begin
          nxt_is_wr[i] = is_wr_ff[i+1];
          nxt_data[i] = data_ff[i+1];
          nxt_tag[i] = tag_ff[i+1];
        end
      end
      nxt_count = count_ff - ewo_pkg::EWO_CNT_ONE;
    end
    if (addr_taken) begin
      nxt_is_wr[nxt_count[ewo_pkg::EWO_IDX_W-1:0]] = addr_req_write;
      nxt_data[nxt_count[ewo_pkg::EWO_IDX_W-1:0]] = addr_req_data;
      nxt_tag[nxt_count[ewo_pkg::EWO_IDX_W-1:0]] = wr_push_tag_ff;
      nxt_count = nxt_count + ewo_pkg::EWO_CNT_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      is_wr_ff <= '0;
      count_ff <= ewo_pkg::EWO_CNT_ZERO;
      for (int i = 0; i < ewo_pkg::EWO_DEPTH; i++) begin
        data_ff[i] <= ewo_pkg::EWO_DATA_ZERO;
        tag_ff[i] <= ewo_pkg::EWO_TAG_ZERO;
      end
    end else begin
      is_wr_ff <= nxt_is_wr;
      count_ff <= nxt_count;
      data_ff <= nxt_data;
      tag_ff <= nxt_tag;
    end
  end

  // write sequence numbers at address grant and at data tenure
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_push_tag_ff <= ewo_pkg::EWO_TAG_ZERO;
      wr_next_tag_ff <= ewo_pkg::EWO_TAG_ZERO;
    end else begin
      if (addr_taken && addr_req_write) begin
        wr_push_tag_ff <= wr_push_tag_ff + ewo_pkg::EWO_TAG_ONE;
      end
      if (start_wr) begin
        wr_next_tag_ff <= wr_next_tag_ff + ewo_pkg::EWO_TAG_ONE;
      end
    end
  end

  // --------------------------------------------------------------------
  // data tenure: busy and data drive for writes, capture for reads
  // --------------------------------------------------------------------
  always_comb begin
    nxt_tenure_st = tenure_st_ff;
    unique case (tenure_st_ff)
      ewo_pkg::EWO_IDLE: begin
        if (start_wr) begin
          nxt_tenure_st = ewo_pkg::EWO_WRITING;
        end
      end
      ewo_pkg::EWO_WRITING: begin
        // write tenure ends after one clock whatever busy reads; busy_oe then drops
        nxt_tenure_st = ewo_pkg::EWO_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tenure_st_ff <= ewo_pkg::EWO_IDLE;
      data_out_ff <= ewo_pkg::EWO_DATA_ZERO;
      write_done_ff <= 1'h0;
    end else begin
      tenure_st_ff <= nxt_tenure_st;
      write_done_ff <= (tenure_st_ff == ewo_pkg::EWO_WRITING);
      if (start_wr) begin
        data_out_ff <= sel_data;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      read_data_ff <= ewo_pkg::EWO_DATA_ZERO;
      read_valid_ff <= 1'h0;
    end else begin
      read_valid_ff <= start_rd;
      if (start_rd) begin
        read_data_ff <= data_bus_in;
      end
    end
  end

  assign data_tenure_busy_oe = (tenure_st_ff == ewo_pkg::EWO_WRITING);
  assign data_tenure_busy_n_out = 1'h0;
  assign data_bus_oe = (tenure_st_ff == ewo_pkg::EWO_WRITING);
  assign data_bus_out = data_out_ff;
  assign read_data = read_data_ff;
  assign read_valid = read_valid_ff;
  assign write_done = write_done_ff;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking ewo_cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_wf_runs_write: assert property (
    qual_grant && wfm && first_wr[ewo_pkg::EWO_IDX_W] |=>
      data_bus_oe && !read_valid_ff)
    else $error("write-first grant did not start a write");

  chk_write_seq_kept: assert property (
    start_wr |-> sel_tag == wr_next_tag_ff)
    else $error("write tenures out of order");

  chk_plain_in_order: assert property (
    qual_grant && !wfm |-> sel_idx == ewo_pkg::EWO_IDX_ZERO)
    else $error("plain grant did not take oldest tenure");

  chk_write_busy_drive: assert property (
    start_wr |=> data_tenure_busy_oe && data_bus_out == $past(sel_data)
      ##1 !data_tenure_busy_oe)
    else $error("write tenure busy or data wrong");

  chk_read_latch: assert property (
    start_rd |=> read_valid_ff && read_data_ff == $past(data_bus_in))
    else $error("read data not latched");

  chk_no_read_order: assert property (
    qual_grant && wfm && !any_read |-> sel_idx == ewo_pkg::EWO_IDX_ZERO)
    else $error("modifier reordered writes without a read");

  chk_addr_capture: assert property (
    addr_taken && !qual_grant |=>
      data_ff[$past(tail_idx)] == $past(addr_req_data))
    else $error("write data not fixed at address grant");

  chk_envelope_kept: assert property (
    start_wr && any_read |=> any_read)
    else $error("enveloping read lost during write");

  chk_idle_stable: assert property (
    !qual_grant && !addr_taken |=> $stable(count_ff) && $stable(is_wr_ff))
    else $error("pending tenures changed without a grant");

  chk_wf_needs_grant: assert property (
    data_tenure_grant_n && tenure_st_ff == ewo_pkg::EWO_IDLE |=>
      !data_bus_oe && !read_valid_ff)
    else $error("tenure started without data grant");

endmodule

// ===== verilog/ewo_pkg.sv
// Purpose: shared constants and types for the enveloped write ordering logic
// Assumes: single-beat data tenures, one bus clock
// Notes: pending tenure queue depth and bus width fixed here

// ----------------------------------------------------------------------
// package
// ----------------------------------------------------------------------
package ewo_pkg;
  localparam int unsigned EWO_DEPTH = 4;
  localparam int unsigned EWO_IDX_W = 2;
  localparam int unsigned EWO_CNT_W = 3;
  localparam int unsigned EWO_DATA_W = 64;
  localparam int unsigned EWO_TAG_W = 3;

  localparam logic [EWO_CNT_W-1:0] EWO_CNT_ZERO = 3'h0;
  localparam logic [EWO_CNT_W-1:0] EWO_CNT_ONE = 3'h1;
  localparam logic [EWO_CNT_W-1:0] EWO_CNT_FULL = 3'h4;
  localparam logic [EWO_IDX_W-1:0] EWO_IDX_ZERO = 2'h0;
  localparam logic [EWO_TAG_W-1:0] EWO_TAG_ZERO = 3'h0;
  localparam logic [EWO_TAG_W-1:0] EWO_TAG_ONE = 3'h1;
  localparam logic [EWO_DATA_W-1:0] EWO_DATA_ZERO = 64'h0;

  typedef enum logic {
    EWO_IDLE,
    EWO_WRITING
  } ewo_tenure_e;
endpackage

// ===== testbench/ewo_arbiter_model.sv
// Purpose: bus arbiter and memory side facing the ordering logic
// Assumes: one bus clock; busy line has a pull-up
// Notes: grants are driven on request from the bench
`timescale 1ns/1ns

module ewo_arbiter_model (
  input wire logic clock,
  input wire logic busy_oe,
  input wire logic busy_n_out,
  input wire logic bus_oe,
  input wire logic [ewo_pkg::EWO_DATA_W-1:0] bus_out,
  output logic address_tenure_grant_n,
  output logic data_tenure_grant_n,
  output logic write_first_modifier_n,
  output logic data_tenure_busy_n_in,
  output logic [ewo_pkg::EWO_DATA_W-1:0] data_bus_in
);
  logic other_busy;
  logic [ewo_pkg::EWO_DATA_W-1:0] drv;

  // ----------------------------------------------------------------------
  // wire levels
  // ----------------------------------------------------------------------
  initial begin
    address_tenure_grant_n = 1'b1;
    data_tenure_grant_n = 1'b1;
    write_first_modifier_n = 1'b1;
    other_busy = 1'b0;
    drv = 64'h0;
  end
  // pull-up: free unless this device or another master holds it low
  assign data_tenure_busy_n_in = ~(busy_oe & ~busy_n_out) &
                                 ~other_busy;
  assign data_bus_in = bus_oe ? bus_out : drv;

  // ----------------------------------------------------------------------
  // grant tasks
  // ----------------------------------------------------------------------
  task agrant(input logic on);
    address_tenure_grant_n <= ~on;
  endtask

  task data_grant(input logic wfm, input logic [63:0] rd);
    @(posedge clock);
    data_tenure_grant_n <= 1'b0;
    write_first_modifier_n <= ~wfm;
    drv <= rd;
    @(posedge clock);
    data_tenure_grant_n <= 1'b1;
    write_first_modifier_n <= 1'b1;
    drv <= ~rd;
  endtask

  task pulse_wfm();
    @(posedge clock);
    write_first_modifier_n <= 1'b0;
    @(posedge clock);
    write_first_modifier_n <= 1'b1;
  endtask

  task set_other(input logic b);
    @(posedge clock);
    other_busy <= b;
  endtask
endmodule

// ===== testbench/tb_enveloped_write_ordering.sv
// Purpose: self-checking bench for the data tenure ordering logic
// Assumes: write tenure holds busy one clock; read data taken at grant
// Notes: reference keeps pending entries in two queues
`timescale 1ns/1ns

module tb_enveloped_write_ordering;
  logic clock;
  logic rst_n;
  logic addr_req_valid;
  logic addr_req_write;
  logic [63:0] addr_req_data;
  logic addr_req_ready;
  logic agn, dgn, wfn, bsy_in, bsy_out, bsy_oe, bus_oe;
  logic [63:0] bus_in, bus_out, read_data;
  logic read_valid, write_done;
  int error_cnt, comparisons;
  integer seed;
  logic qw[$];
  logic [63:0] qd[$];

  always #5 clock = ~clock;

  ewo_enveloped_write_ordering dut (.clock(clock), .rst_n(rst_n),
    .addr_req_valid(addr_req_valid), .addr_req_write(addr_req_write),
    .addr_req_data(addr_req_data), .addr_req_ready(addr_req_ready),
    .address_tenure_grant_n(agn), .data_tenure_grant_n(dgn),
    .write_first_modifier_n(wfn), .data_tenure_busy_n_in(bsy_in),
    .data_tenure_busy_n_out(bsy_out), .data_tenure_busy_oe(bsy_oe),
    .data_bus_in(bus_in), .data_bus_out(bus_out), .data_bus_oe(bus_oe),
    .read_data(read_data), .read_valid(read_valid),
    .write_done(write_done));

  ewo_arbiter_model arb (.clock(clock), .busy_oe(bsy_oe),
    .busy_n_out(bsy_out), .bus_oe(bus_oe), .bus_out(bus_out),
    .address_tenure_grant_n(agn), .data_tenure_grant_n(dgn),
    .write_first_modifier_n(wfn), .data_tenure_busy_n_in(bsy_in),
    .data_bus_in(bus_in));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask

  task push(input logic w);
    logic [63:0] d;
    logic rdy;
    d = {$random(seed), $random(seed)};
    @(posedge clock);
    addr_req_valid <= 1'b1;
    addr_req_write <= w;
    addr_req_data <= d;
    arb.agrant(1'b1);
    #5 rdy = addr_req_ready;
    @(posedge clock);
    addr_req_valid <= 1'b0;
    addr_req_data <= ~d;
    arb.agrant(1'b0);
    if (rdy) begin
      qw.push_back(w);
      qd.push_back(d);
    end
  endtask

  task serve(input logic wfm);
    int i;
    logic [63:0] rd;
    rd = {$random(seed), $random(seed)};
    i = 0;
    if (wfm) begin
      for (int k = qw.size() - 1; k >= 0; k--) begin
        if (qw[k]) i = k;
      end
    end
    arb.data_grant(wfm, rd);
    #1;
    if (qw[i]) begin
      chk(bsy_oe, 64'h1, "busy not driven");
      chk(bsy_out, 64'h0, "busy level");
      chk(bus_oe, 64'h1, "bus not driven");
      chk(bus_out, qd[i], "write data");
      @(posedge clock);
      #1;
      chk(write_done, 64'h1, "write not done");
      chk(bsy_oe, 64'h0, "busy held");
    end else begin
      chk(read_valid, 64'h1, "read not valid");
      chk(read_data, rd, "read data");
    end
    qw.delete(i);
    qd.delete(i);
  endtask

  task complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    seed = 32'hBCB0;
    error_cnt = 0;
    comparisons = 0;
    rst_n = 1'b0;
    addr_req_valid = 1'b0;
    addr_req_write = 1'b0;
    addr_req_data = 64'h0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk(addr_req_ready, 64'h1, "ready after reset");
    chk(bus_oe | bsy_oe | read_valid | write_done, 64'h0,
      "reset outputs");
    push(1'b0);
    push(1'b1);
    push(1'b0);
    serve(1'b0);
    serve(1'b0);
    serve(1'b0);
    $display("test in_order done");
    push(1'b0);
    push(1'b1);
    push(1'b1);
    serve(1'b1);
    serve(1'b1);
    serve(1'b0);
    $display("test envelope done");
    push(1'b1);
    push(1'b1);
    serve(1'b1);
    serve(1'b1);
    $display("test no_read done");
    push(1'b0);
    push(1'b1);
    arb.pulse_wfm();
    arb.set_other(1'b1);
    arb.data_grant(1'b1, 64'h0);
    #1;
    chk(bus_oe | read_valid, 64'h0, "grant taken while busy");
    arb.set_other(1'b0);
    serve(1'b0);
    serve(1'b0);
    $display("test ignored_modifier done");
    push(1'b0);
    push(1'b1);
    push(1'b0);
    push(1'b1);
    #1;
    chk(addr_req_ready, 64'h0, "ready with full queue");
    push(1'b1);
    serve(1'b1);
    serve(1'b1);
    serve(1'b0);
    serve(1'b0);
    $display("test full_queue done");
    complete_run();
  end

  initial begin
    #200000;
    error_cnt++;
    $display("unexpected %0t run limit reached", $time);
    complete_run();
  end
endmodule
